// file: hw/omks_pkg.sv
// Package with constants and types for the operating mode key selector.
package omks_pkg;

   // Clock rate and timing figures.
   localparam int CLK_MHZ          = 100;
   localparam int HOLD_MS          = 500;
   localparam int HOLD_CYCLES      = HOLD_MS * 1000 * CLK_MHZ;
   localparam int DEBOUNCE_US      = 10;
   localparam int DEBOUNCE_CYCLES  = DEBOUNCE_US * CLK_MHZ;
   localparam int BRIEF_MS         = 50;
   localparam int BRIEF_CYCLES     = BRIEF_MS * 1000 * CLK_MHZ;
   localparam int SLOW_HALF_MS     = 500;
   localparam int SLOW_HALF_CYCLES = SLOW_HALF_MS * 1000 * CLK_MHZ;
   localparam int FAST_HALF_MS     = 125;
   localparam int FAST_HALF_CYCLES = FAST_HALF_MS * 1000 * CLK_MHZ;
   localparam int CNT_W            = 32;

   // Key bit positions.
   localparam int KEY_RUN      = 0;
   localparam int KEY_STOP     = 1;
   localparam int KEY_MEMRESET = 2;
   localparam int NKEYS        = 3;

   // Selected controller mode, one-hot free binary code.
   typedef enum logic [1:0] {
      OMKS_MODE_STOP             = 2'h0,
      OMKS_MODE_RUN              = 2'h1,
      OMKS_MODE_MEMORY_RESET     = 2'h2
   } omks_mode_t;

   localparam omks_mode_t MODE_RESET = OMKS_MODE_STOP;

   // Actual controller state reported by the core.
   typedef struct packed {
      logic running;
      logic reset_request;
      logic reset_busy;
   } omks_core_t;

   // Status LED group.
   typedef struct packed {
      logic run_led;
      logic stop_led;
   } omks_status_t;

endpackage

// file: hw/omks_selector.sv
// Operating mode key selector: key debounce, hold timing, authorization and LEDs.
//
// Overview of operation
// - Three modes: run, stop, memory reset.
// - Accepted press selects that key's mode.
// - Accept and light LED after 500 ms.
// - Key LEDs show selector setting only.
// - Keys work only while authorization bridged.
// - Authorization open: key LEDs off, keys ignored.
// - Status LEDs always show core state.
// - Run executes program; stop does not.
// - Stop halts core only, panel stays.
// - Requested reset: brief two-key press starts.
// - Stop LED slow on request, fast resetting.
`timescale 1ns/1ps
module omks_selector
   import omks_pkg::*;
#(
   parameter int HOLD_CNT  = HOLD_CYCLES,
   parameter int BRIEF_CNT = BRIEF_CYCLES,
   parameter int SLOW_CNT  = SLOW_HALF_CYCLES,
   parameter int FAST_CNT  = FAST_HALF_CYCLES
)(
   // Clock and reset.
   input  wire logic             clock,
   input  wire logic             nrst,
   // Front-panel keys and authorization, asynchronous pins.
   input  wire logic [NKEYS-1:0] key_pin,
   input  wire logic             authorization_input_first,
   input  wire logic             authorization_input_second,
   // Controller core report.
   input  wire omks_core_t       core_state,
   // Mode to core and panel outputs.
   output omks_mode_t            mode_sel,
   output logic                  core_exec_en,
   output logic                  memory_reset_mode,
   output logic [NKEYS-1:0]      key_led,
   output omks_status_t          status_led,
   output logic                  panel_active
);

   // Raw pins: keys, then both authorization pins, each synchronized on its own.
   wire [NKEYS+1:0] raw_in = {authorization_input_second, authorization_input_first, key_pin};

   logic [NKEYS+1:0] sync1_reg, sync2_reg;
   // The bridge is judged after synchronizing, so the two pins never race in one gate.
   wire [NKEYS:0] deb_in = {sync2_reg[NKEYS+1] & sync2_reg[NKEYS], sync2_reg[NKEYS-1:0]};
   wire [NKEYS:0] clean_w;
   logic [CNT_W-1:0] brief_reg, blink_reg;
   omks_mode_t mode_reg, mode_next;
   logic blink_reg_led;

   // two-stage synchronizer. The first stage is read only by the second.
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         sync1_reg <= '0;
         sync2_reg <= '0;
      end else begin
         sync1_reg <= raw_in;
         sync2_reg <= sync1_reg;
      end
   end

   // debounce: a level is taken once it stayed stable for a while.
   generate
      for (genvar i = 0; i <= NKEYS; i++) begin : g_deb
         logic [CNT_W-1:0] db_reg;
         logic             level_reg;
         // Continuous chatter keeps the old level, so bounce never reaches the timers.
         always_ff @(posedge clock or negedge nrst) begin
            if (!nrst) begin
               db_reg    <= '0;
               level_reg <= 1'b0;
            end else if (deb_in[i] == level_reg) begin
               db_reg <= '0;
            end else if (db_reg >= CNT_W'(DEBOUNCE_CYCLES - 1)) begin
               db_reg    <= '0;
               level_reg <= deb_in[i];
            end else begin
               db_reg <= db_reg + 1'b1;
            end
         end
         assign clean_w[i] = level_reg;
      end
   endgenerate

   wire auth_ok = clean_w[NKEYS];
   wire [NKEYS-1:0] key_clean = clean_w[NKEYS-1:0];

   // hold timers; each key counts while held and saturates at the limit.
   logic [NKEYS-1:0] held_long;
   generate
      for (genvar k = 0; k < NKEYS; k++) begin : g_hold
         logic [CNT_W-1:0] hold_reg;
         always_ff @(posedge clock or negedge nrst) begin
            if (!nrst) begin
               hold_reg <= '0;
            end else if (!key_clean[k] || !auth_ok) begin
               hold_reg <= '0;
            end else if (hold_reg < CNT_W'(HOLD_CNT)) begin
               hold_reg <= hold_reg + 1'b1;
            end
         end
         assign held_long[k] = (hold_reg == CNT_W'(HOLD_CNT - 1));
      end
   endgenerate

   // brief two-key press: stop and memory reset keys together.
   wire both_keys = key_clean[KEY_STOP] & key_clean[KEY_MEMRESET] & auth_ok;
   // The count saturates, so one long two-key press fires the shortcut only once.
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         brief_reg <= '0;
      end else if (!both_keys) begin
         brief_reg <= '0;
      end else if (brief_reg < CNT_W'(BRIEF_CNT)) begin
         brief_reg <= brief_reg + 1'b1;
      end
   end
   wire brief_hit = both_keys && (brief_reg == CNT_W'(BRIEF_CNT - 1))
                    && core_state.reset_request;

   // next mode from accepted press; memory reset wins over run and stop.
   always_comb begin
      mode_next = mode_reg;
      if (!auth_ok)
         mode_next = mode_reg;
      else if (brief_hit || held_long[KEY_MEMRESET])
         mode_next = OMKS_MODE_MEMORY_RESET;
      else if (held_long[KEY_STOP])
         mode_next = OMKS_MODE_STOP;
      else if (held_long[KEY_RUN])
         mode_next = OMKS_MODE_RUN;
   end

   // flash generator for the stop status LED.
   wire [CNT_W-1:0] half_cnt = core_state.reset_busy ? CNT_W'(FAST_CNT) : CNT_W'(SLOW_CNT);
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         blink_reg     <= '0;
         blink_reg_led <= 1'b0;
      end else if (blink_reg >= half_cnt - 1'b1) begin
         blink_reg     <= '0;
         blink_reg_led <= ~blink_reg_led;
      end else begin
         blink_reg <= blink_reg + 1'b1;
      end
   end

   wire flashing = core_state.reset_busy | core_state.reset_request;
   wire stop_led_next = flashing ? blink_reg_led : ~core_state.running;

   // key LEDs follow the selector setting, dark when unauthorized.
   wire [NKEYS-1:0] key_led_next = !auth_ok ? '0 :
      {mode_next == OMKS_MODE_MEMORY_RESET, mode_next == OMKS_MODE_STOP,
       mode_next == OMKS_MODE_RUN};

   // Registered mode and all outputs.
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         mode_reg          <= MODE_RESET;
         mode_sel          <= MODE_RESET;
         core_exec_en      <= 1'b0;
         memory_reset_mode <= 1'b0;
         key_led           <= '0;
         status_led        <= '0;
         panel_active      <= 1'b0;
      end else begin
         // only three modes are ever stored.
         mode_reg          <= mode_next;
         mode_sel          <= mode_next;
         // program runs only in run mode.
         core_exec_en      <= (mode_next == OMKS_MODE_RUN);
         memory_reset_mode <= (mode_next == OMKS_MODE_MEMORY_RESET);
         key_led           <= key_led_next;
         // status LEDs show the core, whatever the authorization.
         status_led        <= '{run_led: core_state.running, stop_led: stop_led_next};
         // the operator panel stays active in every mode.
         panel_active      <= 1'b1;
      end
   end

   // Checks kept beside the logic.
   sequence s_key_held;
      held_long[KEY_RUN] && auth_ok && !held_long[KEY_STOP] && !held_long[KEY_MEMRESET]
      && !brief_hit;
   endsequence

   hold_run_a: assert property (@(posedge clock) disable iff (!nrst)
      s_key_held |=> mode_sel == OMKS_MODE_RUN && key_led[KEY_RUN])
      else $error("Run key held but run mode not selected.");
   auth_dark_a: assert property (@(posedge clock) disable iff (!nrst)
      !auth_ok |=> key_led == '0)
      else $error("Key LEDs lit while unauthorized.");
   auth_freeze_a: assert property (@(posedge clock) disable iff (!nrst)
      !auth_ok |=> $stable(mode_sel))
      else $error("Mode changed while unauthorized.");
   led_match_a: assert property (@(posedge clock) disable iff (!nrst)
      auth_ok |=> key_led[KEY_STOP] == (mode_sel == OMKS_MODE_STOP))
      else $error("Key LED differs from selector.");
   exec_run_a: assert property (@(posedge clock) disable iff (!nrst)
      core_exec_en == (mode_sel == OMKS_MODE_RUN))
      else $error("Execution enable wrong for mode.");
   mode_legal_a: assert property (@(posedge clock) disable iff (!nrst)
      mode_sel != 2'h3)
      else $error("Illegal mode value.");
   status_run_a: assert property (@(posedge clock) disable iff (!nrst)
      $past(nrst) |-> status_led.run_led == $past(core_state.running))
      else $error("Run status LED does not follow core.");
   brief_reset_a: assert property (@(posedge clock) disable iff (!nrst)
      brief_hit |=> mode_sel == OMKS_MODE_MEMORY_RESET)
      else $error("Brief two-key press did not start reset.");
   panel_on_a: assert property (@(posedge clock) disable iff (!nrst)
      $past(nrst) |-> panel_active)
      else $error("Panel inactive.");
   auth_nokey_a: assert property (@(posedge clock) disable iff (!nrst)
      !auth_ok |=> held_long == '0)
      else $error("Key accepted while unauthorized.");
   noacc_a: assert property (@(posedge clock) disable iff (!nrst)
      held_long == '0 && !brief_hit |=> mode_sel == $past(mode_sel))
      else $error("Mode changed without accepted press.");

endmodule

// file: tb/omks_operator.sv
// Operator model: mode keys and authorization bridge with contact chatter.
`timescale 1ns/1ps
module omks_operator
   import omks_pkg::*;
(
   // Commands from the bench.
   input  wire logic             clock,
   input  wire logic [NKEYS-1:0] key_cmd,
   input  wire logic             bridge_cmd,
   // Pins toward the selector.
   output logic [NKEYS-1:0]      key_pin,
   output logic                  authorization_input_first,
   output logic                  authorization_input_second
);
   logic [NKEYS-1:0] last_reg = 3'h0;
   logic [3:0]       bounce_reg = 4'h0;
   logic             last_bridge_reg = 1'h1;
   logic [3:0]       bridge_bounce_reg = 4'h0;

   // Each contact change chatters for eight cycles, as real contacts do.
   always_ff @(posedge clock) begin
      last_reg <= key_cmd;
      last_bridge_reg <= bridge_cmd;
      if (key_cmd != last_reg) begin
         bounce_reg <= 4'h8;
      end else if (bounce_reg != 4'h0) begin
         bounce_reg <= bounce_reg - 4'h1;
      end
      if (bridge_cmd != last_bridge_reg) begin
         bridge_bounce_reg <= 4'h8;
      end else if (bridge_bounce_reg != 4'h0) begin
         bridge_bounce_reg <= bridge_bounce_reg - 4'h1;
      end
   end

   // An open bridge lets the second pin settle low once its contact stops chattering.
   assign key_pin = bounce_reg[0] ? ~key_cmd : key_cmd;
   assign authorization_input_first = 1'h1;
   assign authorization_input_second = bridge_bounce_reg[0] ? ~bridge_cmd : bridge_cmd;
endmodule

// file: tb/omks_selector_tb.sv
// Self-checking bench for the operating mode key selector.
`timescale 1ns/1ps
module omks_selector_tb;
   import omks_pkg::*;
   logic             clock = 1'h0;
   logic             nrst = 1'h0;
   logic [NKEYS-1:0] key_cmd = 3'h0;
   logic             bridge_cmd = 1'h1;
   omks_core_t       core_state = 3'h0;
   logic [NKEYS-1:0] key_pin;
   logic             auth_a;
   logic             auth_b;
   omks_mode_t       mode_sel;
   logic             exec_en;
   logic             memreset_seen;
   logic [NKEYS-1:0] key_led;
   omks_status_t     status_led;
   logic             panel;
   int               n_mismatch = 0;
   int               checks_done = 0;
   int               cycles = 0;

   // Clock of 100 MHz.
   always #5 clock = ~clock;

   omks_operator op (.clock(clock), .key_cmd(key_cmd), .bridge_cmd(bridge_cmd),
      .key_pin(key_pin), .authorization_input_first(auth_a),
      .authorization_input_second(auth_b));

   // Hold sits above the 1000-cycle debounce so a short press reaches the hold timer.
   omks_selector #(.HOLD_CNT(2000), .BRIEF_CNT(5), .SLOW_CNT(8), .FAST_CNT(4)) dut (
      .clock(clock), .nrst(nrst), .key_pin(key_pin), .authorization_input_first(auth_a),
      .authorization_input_second(auth_b), .core_state(core_state), .mode_sel(mode_sel),
      .core_exec_en(exec_en), .memory_reset_mode(memreset_seen), .key_led(key_led),
      .status_led(status_led), .panel_active(panel));

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic conclude();
      $display("Checks %0d, mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic hold(input logic [NKEYS-1:0] k, input int n);
      @(posedge clock);
      key_cmd <= k;
      repeat (n - 1) @(posedge clock);
      #1;
   endtask

   // Release waits out the debounce so the next press starts clean.
   task automatic release_keys();
      hold(3'h0, 1100);
   endtask

   task automatic flash(input int lo, input int hi);
      int n;
      logic prev;
      n = 0;
      prev = status_led.stop_led;
      repeat (40) begin
         hold(key_cmd, 1);
         n += int'(status_led.stop_led !== prev);
         prev = status_led.stop_led;
      end
      check("stop_flash", 32'(n >= lo && n <= hi), 32'h1);
   endtask

   task automatic t_reset();
      check("mode", mode_sel, OMKS_MODE_STOP);
      check("exec", exec_en, 1'h0);
      check("panel", panel, 1'h1);
      release_keys();
      check("key_led", key_led, 3'h2);
      $display("reset test done");
   endtask

   task automatic t_hold();
      hold(3'h1, 1500);
      release_keys();
      check("short", mode_sel, OMKS_MODE_STOP);
      hold(3'h1, 2900);
      check("early", mode_sel, OMKS_MODE_STOP);
      hold(3'h1, 300);
      check("late", key_led, 3'h1);
      release_keys();
      $display("hold test done");
   endtask

   task automatic t_keys();
      omks_mode_t em [3];
      em = '{OMKS_MODE_RUN, OMKS_MODE_STOP, OMKS_MODE_MEMORY_RESET};
      for (int i = 0; i < 3; i++) begin
         hold(3'h1 << i, 3200);
         check("mode", mode_sel, em[i]);
         check("led", key_led, 3'h1 << i);
         check("exec", exec_en, i == 0);
         check("memreset", memreset_seen, i == 2);
         release_keys();
      end
      $display("key test done");
   endtask

   task automatic t_auth();
      @(posedge clock);
      bridge_cmd <= 1'h0;
      release_keys();
      check("dark", key_led, 3'h0);
      hold(3'h1, 3200);
      check("ignored", mode_sel, OMKS_MODE_MEMORY_RESET);
      @(posedge clock);
      core_state <= 3'h4;
      release_keys();
      check("status", status_led, 2'h2);
      @(posedge clock);
      bridge_cmd <= 1'h1;
      release_keys();
      check("setting", key_led, 3'h4);
      $display("authorization test done");
   endtask

   task automatic t_request();
      @(posedge clock);
      core_state <= 3'h2;
      hold(3'h1, 3200);
      release_keys();
      check("run", mode_sel, OMKS_MODE_RUN);
      flash(4, 6);
      hold(3'h6, 1100);
      release_keys();
      check("brief", mode_sel, OMKS_MODE_MEMORY_RESET);
      @(posedge clock);
      core_state <= 3'h1;
      flash(9, 11);
      $display("request test done");
   endtask

   // A hang is cut short well past the expected 34000 cycles.
   always @(posedge clock) begin
      cycles++;
      if (cycles == 60000) begin
         n_mismatch++;
         conclude();
      end
   end

   initial begin
      repeat (10) @(posedge clock);
      nrst <= 1'h1;
      repeat (3) @(posedge clock);
      #1;
      t_reset();
      t_hold();
      t_keys();
      t_auth();
      t_request();
      conclude();
   end
endmodule
